//--- design/host_port_pin_front_end.sv
// How it works
// - the three register-address pins are captured to select the target register of an access.
// - the two lowest owned pins (port B 6 and 7) are captured as data select with the address and passed with each access.
// - during reset all host pins are released and their inputs ignored.
// - a pin whose host function is off behaves as a plain port-B I/O bit.
// - in single-strobe mode the read/write pin gives the transfer direction.
// - in single-strobe mode a transfer happens only on data strobe with chip select.
// - in double-strobe mode the read/write pin is a read strobe.
// - in double-strobe mode the data-strobe pin is a write strobe.
// - no transfer happens unless chip select is asserted.
// - with request mode 0 one open-drain pin requests service.
// - with request mode 1 that pin becomes the transmit request.
// - with request mode 1 the acknowledge pin becomes the receive request.
`timescale 1ns/1ns
module host_port_pin_front_end (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic [9:0]  hostFuncSel,
  input  wire logic        busModeDouble,
  input  wire logic        request_mode_select,
  input  wire logic        serviceReq,
  input  wire logic        transmitReq,
  input  wire logic        receiveReq,
  input  wire logic [9:0]  gpioOut,
  input  wire logic [9:0]  gpioDir,
  input  wire logic [9:0]  pinIn,
  output logic      [9:0]  pinOut,
  output logic      [9:0]  pinOe_n,
  output logic      [9:0]  gpioIn,
  output logic      [2:0]  regAddr,
  output logic      [1:0]  dataSel,
  output logic             readPulse,
  output logic             writePulse,
  output logic             ackSeen
);
  // pin map (index into the ten owned pins, port B 6..15)
  localparam int P_RW  = host_port_pkg::RW_BIT - host_port_pkg::DATA_SEL_LO_BIT;
  localparam int P_STB = host_port_pkg::STROBE_BIT - host_port_pkg::DATA_SEL_LO_BIT;
  localparam int P_CS  = host_port_pkg::CS_BIT - host_port_pkg::DATA_SEL_LO_BIT;
  localparam int P_REQ = host_port_pkg::REQ_BIT - host_port_pkg::DATA_SEL_LO_BIT;
  localparam int P_ACK = host_port_pkg::ACK_BIT - host_port_pkg::DATA_SEL_LO_BIT;
  localparam int P_AD  = host_port_pkg::ADDR_LO_BIT - host_port_pkg::DATA_SEL_LO_BIT;

  typedef struct packed {
    logic [1:0]                    syncRw;
    logic [1:0]                    syncStb;
    logic [1:0]                    syncCs;
    logic                          rdPrev;
    logic                          wrPrev;
    host_port_pkg::access_state_type state;
    logic [9:0]                    pinOut;
    logic [9:0]                    pinOe_n;
    logic [9:0]                    gpioIn;
    logic [2:0]                    regAddr;
    logic [1:0]                    dataSel;
    logic                          readPulse;
    logic                          writePulse;
    logic                          ackSeen;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic rdLevel;
  logic wrLevel;
  logic hostRw;
  logic hostStb;
  logic hostCs;
  logic rdRise;
  logic wrRise;

  // decode strobes from the second synchroniser stage only, so metastability stays in stage one
  always_comb begin
    hostRw  = st_reg.syncRw[1];
    hostStb = st_reg.syncStb[1];
    hostCs  = st_reg.syncCs[1];
    if (busModeDouble == host_port_pkg::BUS_DOUBLE) begin
      rdLevel = hostCs && hostRw;
      wrLevel = hostCs && hostStb;
    end else begin
      rdLevel = hostCs && hostStb && hostRw;
      wrLevel = hostCs && hostStb && !hostRw;
    end
    rdRise = rdLevel && !st_reg.rdPrev;
    wrRise = wrLevel && !st_reg.wrPrev;
  end

  // next-state: synchronisers, access tracking, pin muxing
  always_comb begin
    st_next = st_reg;
    st_next.syncRw  = {st_reg.syncRw[0],  pinIn[P_RW]  && hostFuncSel[P_RW]};
    st_next.syncStb = {st_reg.syncStb[0], pinIn[P_STB] && hostFuncSel[P_STB]};
    st_next.syncCs  = {st_reg.syncCs[0],  pinIn[P_CS]  && hostFuncSel[P_CS]};
    st_next.rdPrev     = rdLevel;
    st_next.wrPrev     = wrLevel;
    st_next.readPulse  = 1'b0;
    st_next.writePulse = 1'b0;
    case (st_reg.state)
      host_port_pkg::IDLE_ST: begin
        if (rdRise || wrRise) begin
          // address and data select are held stable by the host around the strobe
          st_next.regAddr    = pinIn[P_AD +: 3];
          st_next.dataSel    = pinIn[1:0];
          st_next.readPulse  = rdRise;
          st_next.writePulse = wrRise && !rdRise;
          st_next.state      = host_port_pkg::ACCESS_ST;
        end
      end
      host_port_pkg::ACCESS_ST: begin
        // one pulse per strobe; wait for release before the next access
        if (!rdLevel && !wrLevel) begin
          st_next.state = host_port_pkg::DONE_ST;
        end
      end
      host_port_pkg::DONE_ST: begin
        st_next.state = host_port_pkg::IDLE_ST;
      end
      default: begin
        st_next.state = host_port_pkg::IDLE_ST;
      end
    endcase
    // general-purpose pins: driven per direction bit and read back, only while the host function is off
    for (int i = 0; i < host_port_pkg::PIN_COUNT; i++) begin
      st_next.gpioIn[i]  = hostFuncSel[i] ? 1'b0 : pinIn[i];
      st_next.pinOut[i]  = gpioOut[i];
      st_next.pinOe_n[i] = hostFuncSel[i] ? 1'b1 : !gpioDir[i];
    end
    // request pins: pull low only while the request is up
    if (hostFuncSel[P_REQ]) begin
      st_next.pinOut[P_REQ]  = 1'b0;
      if (request_mode_select == host_port_pkg::REQ_MODE_SINGLE) begin
        st_next.pinOe_n[P_REQ] = !serviceReq;
      end else begin
        st_next.pinOe_n[P_REQ] = !transmitReq;
      end
    end
    if (hostFuncSel[P_ACK]) begin
      st_next.pinOut[P_ACK] = 1'b0;
      if (request_mode_select == host_port_pkg::REQ_MODE_SPLIT) begin
        st_next.pinOe_n[P_ACK] = !receiveReq;
        st_next.ackSeen        = 1'b0;
      end else begin
        st_next.pinOe_n[P_ACK] = 1'b1;
        st_next.ackSeen        = !pinIn[P_ACK];
      end
    end else begin
      st_next.ackSeen = 1'b0;
    end
  end

  // single register for all state; reset isolates every pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.syncRw     <= 2'h0;
      st_reg.syncStb    <= 2'h0;
      st_reg.syncCs     <= 2'h0;
      st_reg.rdPrev     <= 1'b0;
      st_reg.wrPrev     <= 1'b0;
      st_reg.state      <= host_port_pkg::IDLE_ST;
      st_reg.pinOut     <= host_port_pkg::PIN_OUT_RESET;
      st_reg.pinOe_n    <= 10'h3FF;
      st_reg.gpioIn     <= 10'h000;
      st_reg.regAddr    <= host_port_pkg::ADDR_RESET;
      st_reg.dataSel    <= host_port_pkg::DSEL_RESET;
      st_reg.readPulse  <= 1'b0;
      st_reg.writePulse <= 1'b0;
      st_reg.ackSeen    <= 1'b0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign pinOut     = st_reg.pinOut;
  assign pinOe_n    = st_reg.pinOe_n;
  assign gpioIn     = st_reg.gpioIn;
  assign regAddr    = st_reg.regAddr;
  assign dataSel    = st_reg.dataSel;
  assign readPulse  = st_reg.readPulse;
  assign writePulse = st_reg.writePulse;
  assign ackSeen    = st_reg.ackSeen;

  // checks
  reset_isolate_a: assert property (@(posedge ref_clk) $past(rst) |-> pinOe_n == 10'h3FF)
    else $error("pins driven after reset");
  no_cs_access_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.syncCs[1] && clkEn) |=> !readPulse && !writePulse)
    else $error("access without chip select");
  single_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
    (busModeDouble == 1'b0 && !st_reg.syncStb[1] && clkEn) |=> !writePulse && !readPulse)
    else $error("single-strobe access without data strobe");
  req_pull_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && hostFuncSel[P_REQ] && !request_mode_select) |=> pinOe_n[P_REQ] == !$past(serviceReq))
    else $error("service request pin wrong");
  tx_req_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && hostFuncSel[P_REQ] && request_mode_select) |=> pinOe_n[P_REQ] == !$past(transmitReq))
    else $error("transmit request pin wrong");
  rx_req_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && hostFuncSel[P_ACK] && request_mode_select) |=> pinOe_n[P_ACK] == !$past(receiveReq))
    else $error("receive request pin wrong");
  // a frozen clock keeps the old pin value, so only judge after an enabled edge
  od_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (hostFuncSel[P_REQ] && $past(hostFuncSel[P_REQ]) && $past(clkEn) && !pinOe_n[P_REQ])
    |-> !pinOut[P_REQ])
    else $error("request pin drives high");
  gpio_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !hostFuncSel[0]) |=> pinOe_n[0] == !$past(gpioDir[0]))
    else $error("gpio direction wrong");
  sync_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !hostFuncSel[P_CS]) ##1 clkEn ##1 clkEn |-> !st_reg.syncCs[1])
    else $error("chip select passed without sync");
  // one access never raises both pulses, so the register side sees one direction
  pulse_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(readPulse && writePulse))
    else $error("read and write pulse together");
  // the captured selection only moves with an access pulse
  addr_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!readPulse && !writePulse && !$past(rst))
    |-> $stable(regAddr) && $stable(dataSel))
    else $error("register select moved without access");
  // main scenarios
  read_cov: cover property (@(posedge ref_clk) readPulse);
  write_cov: cover property (@(posedge ref_clk) writePulse);
  double_write_cov: cover property (@(posedge ref_clk) busModeDouble && writePulse);
  split_req_cov: cover property (@(posedge ref_clk) request_mode_select && !pinOe_n[P_ACK]);
  ack_cov: cover property (@(posedge ref_clk) ackSeen);
endmodule : host_port_pin_front_end

//--- design/host_port_pkg.sv
package host_port_pkg;
  // pin indices within port B for the pins this front end owns
  localparam int          DATA_SEL_LO_BIT  = 6;
  localparam int          ADDR_LO_BIT      = 8;
  localparam int          RW_BIT           = 11;
  localparam int          STROBE_BIT       = 12;
  localparam int          CS_BIT           = 13;
  localparam int          REQ_BIT          = 14;
  localparam int          ACK_BIT          = 15;
  localparam int          PIN_COUNT        = 10;
  // request-mode select encodings
  localparam logic        REQ_MODE_SINGLE  = 1'h0;
  localparam logic        REQ_MODE_SPLIT   = 1'h1;
  // bus mode encodings
  localparam logic        BUS_SINGLE       = 1'h0;
  localparam logic        BUS_DOUBLE       = 1'h1;
  // reset values
  localparam logic [9:0]  PIN_OUT_RESET    = 10'h000;
  localparam logic [2:0]  ADDR_RESET       = 3'h0;
  localparam logic [1:0]  DSEL_RESET       = 2'h0;
  // synchroniser depth
  localparam int          SYNC_STAGES      = 2;

  typedef enum logic [1:0] {
    IDLE_ST   = 2'b00,
    ACCESS_ST = 2'b01,
    DONE_ST   = 2'b10
  } access_state_type;
endpackage : host_port_pkg

//--- verification/host_model.sv
`timescale 1ns/1ns
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [9:0] pinOut,
  input  wire logic [9:0] pinOe_n,
  output logic      [9:0] pinIn
);
  logic [9:0] drv;
  // device drives where enabled; host value or pull-up elsewhere
  assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & drv);
  initial drv = 10'h300;
  // one access; strobe held well past the answer, then low for 3 cycles
  task automatic access(input logic [2:0] a, input logic [1:0] d, input logic rd,
                        input logic dbl, input logic cs);
    @(negedge ref_clk);
    drv[4:0] = {a, d};
    drv[5] = rd;
    drv[6] = dbl ? ~rd : 1'b1;
    drv[7] = cs;
    repeat (6) @(negedge ref_clk);
    drv[7:5] = 3'h0;
    drv[4:0] = ~drv[4:0]; // released lines must not keep their value
    repeat (3) @(negedge ref_clk);
  endtask : access
endmodule : host_model

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic       ref_clk = 1'b0, rst = 1'b1, busModeDouble = 1'b0, request_mode_select = 1'b0;
  logic       serviceReq = 1'b0, transmitReq = 1'b0, receiveReq = 1'b0;
  logic       clkEn = 1'b1;
  logic [9:0] hostFuncSel = 10'h3FF, gpioOut = 10'h000, gpioDir = 10'h000;
  logic [9:0] pinIn, pinOut, pinOe_n, gpioIn;
  logic [2:0] regAddr, capA;
  logic [1:0] dataSel, capD;
  logic       readPulse, writePulse, ackSeen;
  int         bad_count = 0, total_checks = 0, rdCnt = 0, wrCnt = 0;
  // 25 MHz reference
  always #20 ref_clk = ~ref_clk;
  host_port_pin_front_end i_host_port_pin_front_end (.ref_clk(ref_clk), .rst(rst),
    .clkEn(clkEn), .hostFuncSel(hostFuncSel), .busModeDouble(busModeDouble),
    .request_mode_select(request_mode_select), .serviceReq(serviceReq),
    .transmitReq(transmitReq), .receiveReq(receiveReq), .gpioOut(gpioOut),
    .gpioDir(gpioDir), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .gpioIn(gpioIn), .regAddr(regAddr), .dataSel(dataSel), .readPulse(readPulse),
    .writePulse(writePulse), .ackSeen(ackSeen));
  host_model i_host_model (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pinIn(pinIn));
  // pulses are tallied on the falling edge, where the registered outputs have settled
  always @(negedge ref_clk) begin
    if (readPulse === 1'b1) rdCnt++;
    if (writePulse === 1'b1) wrCnt++;
    if ((readPulse | writePulse) === 1'b1) begin
      capA = regAddr;
      capD = dataSel;
    end
  end
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic xfer(input logic [2:0] a, input logic [1:0] d, input logic rd,
                      input logic cs, input int er, input int ew);
    int r0;
    int w0;
    r0 = rdCnt;
    w0 = wrCnt;
    i_host_model.access(a, d, rd, busModeDouble, cs);
    chk("reads", 10'(er), 10'(rdCnt - r0));
    chk("writes", 10'(ew), 10'(wrCnt - w0));
    if (er + ew > 0) chk("addr", 10'({d, a}), 10'({capD, capA}));
  endtask : xfer
  task automatic req(input logic m, input logic s, input logic t, input logic r,
                     input logic [1:0] e);
    @(negedge ref_clk);
    {request_mode_select, serviceReq, transmitReq, receiveReq} = {m, s, t, r};
    repeat (3) @(negedge ref_clk);
    chk("reqPins", 10'(e), 10'(pinIn[9:8]));
  endtask : req
  task automatic test_reset;
    repeat (2) @(negedge ref_clk);
    chk("resetOe", 10'h3FF, pinOe_n);
    chk("resetIn", 10'h000, gpioIn);
    rst = 1'b0;
    $display("reset test done");
  endtask : test_reset
  // every address in both bus modes, alternating direction back to back
  task automatic test_access;
    for (int m = 0; m < 2; m++) begin
      busModeDouble = m[0];
      for (int i = 0; i < 8; i++) xfer(3'(i), 2'(i + m), i[0], 1'b1, i % 2, 1 - i % 2);
    end
    busModeDouble = 1'b0;
    $display("access test done");
  endtask : test_access
  task automatic test_refuse;
    int r0;
    r0 = rdCnt + wrCnt;
    // double-strobe pin pattern in single mode: chip select and read/write up, data strobe low
    i_host_model.access(3'h5, 2'h2, 1'b1, 1'b1, 1'b1);
    chk("noStrobe", 10'h000, 10'(rdCnt + wrCnt - r0));
    xfer(3'h3, 2'h1, 1'b1, 1'b0, 0, 0);
    hostFuncSel[7] = 1'b0;
    xfer(3'h3, 2'h1, 1'b0, 1'b1, 0, 0);
    hostFuncSel[7] = 1'b1;
    $display("refuse test done");
  endtask : test_refuse
  task automatic test_request;
    req(1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
    req(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
    req(1'b1, 1'b0, 1'b1, 1'b0, 2'h2);
    req(1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
    req(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
    i_host_model.drv[9] = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("ackSeen", 10'h001, 10'(ackSeen));
    i_host_model.drv[9] = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("ackGone", 10'h000, 10'(ackSeen));
    $display("request test done");
  endtask : test_request
  task automatic test_gpio;
    {hostFuncSel, gpioDir, gpioOut} = {10'h000, 10'h3FF, 10'h2A5};
    repeat (3) @(negedge ref_clk);
    chk("gpioOe", 10'h000, pinOe_n);
    chk("gpioOut", 10'h2A5, pinOut);
    // a reset in mid-run must release pins that were driving
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("midResetOe", 10'h3FF, pinOe_n);
    chk("midResetOut", host_port_pkg::PIN_OUT_RESET, pinOut);
    // with the clock enable low nothing may move, not even the output enables
    {rst, clkEn, gpioOut} = {1'b0, 1'b0, 10'h0F0};
    repeat (3) @(negedge ref_clk);
    chk("frozenOe", 10'h3FF, pinOe_n);
    clkEn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("gpioOut2", 10'h0F0, pinOut);
    chk("gpioOe2", 10'h000, pinOe_n);
    gpioDir = 10'h000;
    i_host_model.drv = 10'h15A;
    repeat (4) @(negedge ref_clk);
    chk("gpioIn", 10'h15A, gpioIn);
    $display("gpio test done");
  endtask : test_gpio
  // main sequence; watchdog cuts a hang short
  initial begin
    test_reset();
    test_access();
    test_refuse();
    test_request();
    test_gpio();
    finish_test();
  end
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule : testbench
